// *** cc_io_control.sv ***
// AHB-Lite capture/compare block: io function control, two general registers
// How it works
// [RQ1] control register clears on reset and on either standby entry
// [RQ2] bits 7 and 3 read as zero; software writes zero there
// [RQ3] two 3-bit fields; top bit picks compare or capture
// [RQ4] field zero disables compare-match; pin level left undefined
// [RQ5] code 001 drives pin low on compare-match
// [RQ6] code 010 drives pin high on compare-match
// [RQ7] code 011 toggles pin on compare-match
// [RQ8] code 101 captures on rising edge; 100 never captures
// [RQ9] code 110 captures on falling edge
// [RQ10] code 111 captures on both edges
// [RQ11] capture modes block software writes to that general register
// [RQ12] upper field serves second register/pin, lower field the first
// [RQ13] each capture or match sets a flag; enabled flags raise interrupt
// [RQ14] capture copies the counter; match when counter equals register
// [RQ15] pins are synchronised before edge detection
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cc_consts.svh"
module cc_io_control (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic        first_timer_pin_in,
  output logic             first_timer_pin_out,
  output logic             first_timer_pin_oe_n,
  input  wire logic        second_timer_pin_in,
  output logic             second_timer_pin_out,
  output logic             second_timer_pin_oe_n,
  output logic             irq
);
  logic [7:0]  channel_io_function_control;
  logic [15:0] free_running_counter;
  logic [1:0]  status;
  logic [1:0]  interrupt_enable_reg;
  logic [11:0] addr_q;
  logic        write_q;
  logic        active_q;
  logic [7:0]  next_ioctl;
  logic [15:0] next_counter;
  logic [1:0]  next_status;
  logic [1:0]  next_irq_en;
  logic [31:0] next_hrdata;
  logic        standby;
  logic        wr_phase;
  logic        rd_addr;
  logic        wr_first;
  logic        wr_second;
  logic [15:0] general_reg_first;
  logic [15:0] general_reg_second;
  logic [1:0]  events;

  assign standby = hw_standby | sw_standby;
  // zero wait-state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_phase = active_q && write_q;
  // read decoded in the address phase so hrdata stands through the data phase
  assign rd_addr = hsel && hready && htrans[1] && !hwrite;
  assign wr_first = wr_phase && (addr_q == `CC_OFS_GR_FIRST);
  assign wr_second = wr_phase && (addr_q == `CC_OFS_GR_SECOND);

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q   <= 12'h000;
      write_q  <= 1'b0;
      active_q <= 1'b0;
    end else begin
      addr_q   <= haddr;
      write_q  <= hwrite;
      active_q <= hsel && hready && htrans[1];
    end
  end

  // next values for the control, counter, flags and read data
  always_comb begin
    next_ioctl   = channel_io_function_control;
    next_counter = free_running_counter + 16'h0001;
    next_irq_en  = interrupt_enable_reg;
    next_status  = status;
    next_hrdata  = 32'h0000_0000;
    if (wr_phase) begin
      unique case (addr_q)
        `CC_OFS_IOCTL:   next_ioctl = hwdata[7:0] & `CC_IOCTL_MASK; // RQ2
        `CC_OFS_COUNTER: next_counter = hwdata[15:0];
        `CC_OFS_STATUS:  next_status = status & hwdata[1:0];
        `CC_OFS_IRQ_EN:  next_irq_en = hwdata[1:0];
        default:         next_ioctl = channel_io_function_control;
      endcase
    end
    // an event in the clearing cycle is kept: set beats clear
    next_status = next_status | events; // RQ13
    if (rd_addr) begin
      unique case (haddr)
        `CC_OFS_IOCTL:     next_hrdata = {24'h00_0000, channel_io_function_control}; // RQ2
        `CC_OFS_GR_FIRST:  next_hrdata = {16'h0000, general_reg_first};
        `CC_OFS_GR_SECOND: next_hrdata = {16'h0000, general_reg_second};
        `CC_OFS_COUNTER:   next_hrdata = {16'h0000, free_running_counter};
        `CC_OFS_STATUS:    next_hrdata = {30'h0000_0000, status};
        `CC_OFS_IRQ_EN:    next_hrdata = {30'h0000_0000, interrupt_enable_reg};
        default:           next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // register everything; standby forces the documented reset state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_io_function_control <= `CC_IOCTL_RESET; // RQ1
      free_running_counter        <= 16'h0000;
      status                      <= 2'b00;
      interrupt_enable_reg        <= 2'b00;
      hrdata                      <= 32'h0000_0000;
    end else if (standby) begin
      channel_io_function_control <= `CC_IOCTL_RESET; // RQ1
      free_running_counter        <= 16'h0000;
      status                      <= 2'b00;
      interrupt_enable_reg        <= 2'b00;
      hrdata                      <= 32'h0000_0000;
    end else begin
      channel_io_function_control <= next_ioctl;
      free_running_counter        <= next_counter;
      status                      <= next_status;
      interrupt_enable_reg        <= next_irq_en;
      hrdata                      <= next_hrdata;
    end
  end

  assign irq = |(status & interrupt_enable_reg); // RQ13

  // lower field serves the first register, upper field the second
  cc_channel u_first (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .standby     (standby),
    .func        (channel_io_function_control[`CC_FIRST_LSB +: 3]), // RQ12
    .counter     (free_running_counter),
    .wr_en       (wr_first),
    .wr_data     (hwdata[15:0]),
    .pin_in      (first_timer_pin_in),
    .gr          (general_reg_first),
    .pin_out     (first_timer_pin_out),
    .pin_oe_n    (first_timer_pin_oe_n),
    .event_pulse (events[0])
  );
  cc_channel u_second (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .standby     (standby),
    .func        (channel_io_function_control[`CC_SECOND_LSB +: 3]), // RQ12
    .counter     (free_running_counter),
    .wr_en       (wr_second),
    .wr_data     (hwdata[15:0]),
    .pin_in      (second_timer_pin_in),
    .gr          (general_reg_second),
    .pin_out     (second_timer_pin_out),
    .pin_oe_n    (second_timer_pin_oe_n),
    .event_pulse (events[1])
  );

  a_standby_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
    standby |=> (channel_io_function_control == 8'h00))
    else $error("control not cleared by standby");
  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
    (channel_io_function_control[7] == 1'b0) && (channel_io_function_control[3] == 1'b0))
    else $error("reserved control bit set");
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
    (!standby && events[0]) |=> status[0])
    else $error("event flag not set");
endmodule
`default_nettype wire

// *** cc_consts.svh ***
// register offsets, field positions, reset values for the capture/compare block
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH
`define CC_OFS_IOCTL      12'h000
`define CC_OFS_GR_FIRST   12'h004
`define CC_OFS_GR_SECOND  12'h008
`define CC_OFS_COUNTER    12'h00C
`define CC_OFS_STATUS     12'h010
`define CC_OFS_IRQ_EN     12'h014
`define CC_IOCTL_RESET    8'h00
`define CC_IOCTL_MASK     8'h77
`define CC_FIRST_LSB      0
`define CC_SECOND_LSB     4
`define CC_GR_RESET       16'hFFFF
`endif

// *** cc_pkg.sv ***
// types for the capture/compare block
package cc_pkg;
  typedef enum logic [2:0] {
    FN_OFF     = 3'b000,
    FN_DRIVE0  = 3'b001,
    FN_DRIVE1  = 3'b010,
    FN_TOGGLE  = 3'b011,
    FN_CAP_OFF = 3'b100,
    FN_CAP_RISE = 3'b101,
    FN_CAP_FALL = 3'b110,
    FN_CAP_BOTH = 3'b111
  } func_t;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_state_t;
endpackage

// *** cc_channel.sv ***
// one general register with its pin: compare output or input capture
`timescale 1ns/1ns
`default_nettype none
`include "cc_consts.svh"
module cc_channel (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        standby,
  input  wire logic [2:0]  func,
  input  wire logic [15:0] counter,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        pin_in,
  output logic [15:0]      gr,
  output logic             pin_out,
  output logic             pin_oe_n,
  output logic             event_pulse
);
  logic       sync_a;
  logic       sync_b;
  logic       pin_prev;
  logic [15:0] next_gr;
  logic       next_pin_out;
  logic       next_event;
  logic       rise;
  logic       fall;
  logic       cap;
  logic       match;
  cc_pkg::func_t f;

  // two-flop synchroniser then edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a   <= 1'b0;
      sync_b   <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      sync_a   <= pin_in; // RQ15
      sync_b   <= sync_a;
      pin_prev <= sync_b;
    end
  end

  // decode function field into match, edge and next values
  always_comb begin
    f = cc_pkg::func_t'(func); // RQ3
    rise = sync_b & ~pin_prev;
    fall = ~sync_b & pin_prev;
    // field 000 suppresses detection altogether
    match = ~func[2] && (func != 3'b000) && (counter == gr); // RQ4 RQ14
    cap = 1'b0;
    next_gr = gr;
    next_pin_out = pin_out;
    unique case (f)
      cc_pkg::FN_OFF:      next_pin_out = pin_out;
      cc_pkg::FN_DRIVE0:   if (match) next_pin_out = 1'b0; // RQ5
      cc_pkg::FN_DRIVE1:   if (match) next_pin_out = 1'b1; // RQ6
      cc_pkg::FN_TOGGLE:   if (match) next_pin_out = ~pin_out; // RQ7
      cc_pkg::FN_CAP_OFF:  cap = 1'b0; // RQ8
      cc_pkg::FN_CAP_RISE: cap = rise; // RQ8
      cc_pkg::FN_CAP_FALL: cap = fall; // RQ9
      cc_pkg::FN_CAP_BOTH: cap = rise | fall; // RQ10
    endcase
    // capture modes lock out software, so only a capture changes the register
    if (cap) begin
      next_gr = counter; // RQ14
    end else if (wr_en && !func[2]) begin
      next_gr = wr_data; // RQ11
    end
    next_event = cap | match; // RQ13
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gr          <= `CC_GR_RESET;
      pin_out     <= 1'b0;
      event_pulse <= 1'b0;
    end else if (standby) begin
      gr          <= `CC_GR_RESET;
      pin_out     <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      gr          <= next_gr;
      pin_out     <= next_pin_out;
      event_pulse <= next_event;
    end
  end

  // pin drives only while the register is a compare register
  assign pin_oe_n = func[2]; // RQ3

  a_drive_low: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
    (!standby && func == 3'b001 && match) |=> (pin_out == 1'b0))
    else $error("drive-low compare did not clear pin");
  a_toggle_pin: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    (!standby && func == 3'b011 && match) |=> (pin_out != $past(pin_out)))
    else $error("toggle compare did not invert pin");
  a_rise_cap: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    (!standby && func == 3'b101 && sync_b && !pin_prev) |=> (gr == $past(counter)))
    else $error("rising edge not captured");
  a_fall_cap: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
    (!standby && func == 3'b110 && !sync_b && pin_prev) |=> (gr == $past(counter)))
    else $error("falling edge not captured");
  a_write_block: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    (!standby && func[2] && !cap && wr_en) |=> $stable(gr))
    else $error("write reached capture register");
  a_off_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
    (func == 3'b000) |-> !match)
    else $error("match seen with function off");
endmodule
`default_nettype wire

// *** cc_pin_model.sv ***
// far-side signal source facing one timer pin of the block
`timescale 1ns/1ns
`default_nettype none
module cc_pin_model (
  input  wire logic ext_level,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin
);
  // source drives only while the block has released the pin; no pull, so the
  // released level is whatever the bench commands, never a held stale value
  always_comb begin
    pin = pin_oe_n ? ext_level : pin_out;
  end
endmodule
`default_nettype wire

// *** test_dual_channel_capture_compare_io_control.sv ***
// self-checking bench for the capture/compare io control block
`timescale 1ns/1ns
`default_nettype none
module test_dual_channel_capture_compare_io_control;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hw_standby = 1'b0;
  logic        sw_standby = 1'b0;
  logic [1:0]  ext = 2'b00;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire  [1:0]  pin;
  wire  [1:0]  pin_out;
  wire  [1:0]  pin_oe_n;
  wire         irq;
  int          error_cnt = 0;
  int          checks = 0;
  logic [31:0] rd;
  logic [31:0] g0;
  logic [31:0] r1;
  logic [31:0] r2;
  logic [11:0] gra;
  logic [2:0]  code;
  logic        prev;
  logic        oth;
  logic        hit;
  logic [2:0]  cmp_code [4] = '{3'b010, 3'b001, 3'b011, 3'b000};
  logic [2:0]  cap_code [7] = '{3'b100, 3'b101, 3'b101, 3'b110, 3'b110, 3'b111, 3'b111};
  logic        cap_hit  [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

  // free-running bus clock, 10 ns
  always #5 hclk = ~hclk;

  cc_io_control cc_io_control_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .first_timer_pin_in(pin[0]),
    .first_timer_pin_out(pin_out[0]), .first_timer_pin_oe_n(pin_oe_n[0]),
    .second_timer_pin_in(pin[1]), .second_timer_pin_out(pin_out[1]),
    .second_timer_pin_oe_n(pin_oe_n[1]), .irq(irq));

  // one far-side source per pin
  for (genvar k = 0; k < 2; k++) begin : side
    cc_pin_model cc_pin_model_i (.ext_level(ext[k]), .pin_out(pin_out[k]),
                                 .pin_oe_n(pin_oe_n[k]), .pin(pin[k]));
  end

  task automatic final_report();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask

  // bounded wait for hready; a stuck bus ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        final_report();
      end
      @(posedge hclk);
    end
    // read data taken at the very edge that samples hready high
    rd = hrdata;
    #1;
  endtask

  // single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? d : 32'h0000_0000;
    wait_ready();
  endtask

  initial begin
    cycles(10);
    hresetn <= 1'b1;
    cycles(1);
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, 12'h000, 32'h0000_00ff);
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0077);
    // both standby kinds clear the control register
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 12'h000, 32'h0000_0055);
      hw_standby <= (s == 0);
      sw_standby <= (s == 1);
      cycles(2);
      hw_standby <= 1'b0;
      sw_standby <= 1'b0;
      cycles(1);
      bus(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    bus(1'b1, 12'h020, 32'h0000_00aa);
    bus(1'b0, 12'h020, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test reset_standby_map done");
    // compare codes per channel; counter set just below the register value
    for (int ch = 0; ch < 2; ch++) begin
      gra = 12'h004 + 12'(4 * ch);
      for (int i = 0; i < 4; i++) begin
        code = cmp_code[i];
        prev = pin_out[ch];
        oth = pin_out[1 - ch];
        bus(1'b1, 12'h000, 32'(code) << (4 * ch));
        bus(1'b1, gra, 32'h0000_0100);
        bus(1'b1, 12'h00c, 32'h0000_00f0);
        cycles(40);
        g0 = (code == 3'b010) ? 1 : (code == 3'b001) ? 0 : (code == 3'b011) ? !prev : prev;
        chk(32'(pin_out[ch]), g0);
        chk(32'(pin_oe_n[ch]), 32'h0000_0000);
        chk(32'(pin_out[1 - ch]), 32'(oth));
      end
    end
    $display("test compare_codes done");
    bus(1'b1, 12'h014, 32'h0000_0003);
    // capture codes; each entry flips the far-side level once
    for (int ch = 0; ch < 2; ch++) begin
      gra = 12'h004 + 12'(4 * ch);
      for (int i = 0; i < 7; i++) begin
        hit = cap_hit[i];
        bus(1'b1, 12'h000, 32'(cap_code[i]) << (4 * ch));
        bus(1'b1, 12'h010, 32'h0000_0000);
        bus(1'b0, gra, 32'h0000_0000);
        g0 = rd;
        bus(1'b0, 12'h00c, 32'h0000_0000);
        r1 = rd;
        ext[ch] <= ~ext[ch];
        cycles(8);
        bus(1'b0, 12'h00c, 32'h0000_0000);
        r2 = rd;
        bus(1'b0, gra, 32'h0000_0000);
        if (hit) begin
          chk(32'(rd > r1 && rd < r2), 32'h0000_0001);
        end else begin
          chk(rd, g0);
        end
        chk(32'(pin_oe_n[ch]), 32'h0000_0001);
        g0 = rd;
        bus(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'(hit) << ch);
        chk(32'(irq), 32'(hit));
        bus(1'b1, gra, 32'h0000_1234);
        bus(1'b0, gra, 32'h0000_0000);
        if (cap_code[i] != 3'b100) begin
          chk(rd, g0);
        end
      end
    end
    $display("test capture_codes done");
    final_report();
  end
endmodule
`default_nettype wire
